// [dpp_defines.vh]
// constants for the dual port pin function control block
// assumes an AXI4-Lite register slave with 32-bit data, one word per register
`ifndef DPP_DEFINES_VH
`define DPP_DEFINES_VH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define DPP_IDX_CONFIG 8'h00
`define DPP_IDX_A_DATA 8'h11
`define DPP_IDX_A_DIR 8'h13
`define DPP_IDX_A_IO 8'h15
`define DPP_IDX_A_ACK 8'h17
`define DPP_IDX_B_DATA 8'h19
`define DPP_IDX_B_DATA_ALIAS 8'h1b
`define DPP_IDX_B_DIR 8'h1d
`define DPP_IDX_B_FUNC 8'h1f

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define DPP_INT_SEL_BIT 0
`define DPP_RST_CONFIG 1'h0
`define DPP_RST_A_IO 8'hff
`define DPP_RST_A_ACK 8'h00
`define DPP_RST_DIR 8'h00
`define DPP_RST_DATA 8'h00
`define DPP_RST_B_FUNC 8'hff
`define DPP_B_CS_PINS 8'hf0
`define DPP_B_CS_BASE 4
`define DPP_B_CLKMODE_PIN 0

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define DPP_RESP_OKAY 2'h0
`define DPP_RESP_DECERR 2'h3

`endif

// [dpp_port_ctrl.v]
// pin function, direction and data control for two 8-bit ports
// assumes core signals and pins synchronous to aclk; axi4-lite master on the bus side
//
// Behaviour
// - port a io bit: general io, else address
// - io assign overrides ack assign
// - port a io assign resets to ones
// - port a ack bit makes ack output
// - ack assign bit 0 does nothing
// - ack asserts with level match, strobe timing
// - direction set output, clear input, io only
// - port a latch drives io outputs
// - port a read: pin for inputs, else latch
// - port b set bit: irq or chip select
// - clear bit: io, or cs on pins 7..4 if select zero
// - port b function resets ones, clock-mode inert
// - port b data seen at two addresses
// - port b latch drives io outputs
// - port b read: latch for outputs, else pin
`timescale 1ns/1ps
`include "dpp_defines.vh"

// ------------------------------------------------------------
// register map, byte address is four times the index
// ------------------------------------------------------------
// 0x00 config: bit 0 interrupt select
// 0x11 port a data latch
// 0x13 port a direction
// 0x15 port a io assign
// 0x17 port a ack assign
// 0x19 port b data, 0x1b same latch
// 0x1d port b direction
// 0x1f port b function assign

module dpp_port_ctrl #(
   parameter ADDR_W = 12
) (
   input wire aclk,
   input wire aresetn,
   // register bus
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // core side
   input wire [7:0] core_addr_hi,
   input wire core_as_n,
   input wire core_int_ack_active,
   input wire [2:0] core_int_ack_level,
   input wire [3:0] core_cs_n,
   output reg [7:0] core_irq_n,
   // port a pins
   input wire [7:0] a_pin_in,
   output reg [7:0] a_pin_out,
   output reg [7:0] a_pin_oe_n,
   // port b pins
   input wire [7:0] b_pin_in,
   output reg [7:0] b_pin_out,
   output reg [7:0] b_pin_oe_n
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg full_interrupt_select;
   reg [7:0] port_a_io_assign;
   reg [7:0] port_a_ack_assign;
   reg [7:0] port_a_direction;
   reg [7:0] first_port_data;
   reg [7:0] port_b_function_assign;
   reg [7:0] port_b_direction;
   reg [7:0] second_port_data;

   reg aw_got;
   reg w_got;
   reg [7:0] aw_idx;
   reg [7:0] w_byte;
   reg w_lane0;
   reg next_aw_got;
   reg next_w_got;
   reg next_bvalid;
   reg do_write;

   // ------------------------------------------------------------
   // pin function decode
   // ------------------------------------------------------------
   wire [7:0] a_gio;
   wire [7:0] a_ack;
   wire [7:0] b_cs;
   wire [7:0] b_irq;
   wire [7:0] b_gio;
   wire [7:0] a_read;
   wire [7:0] b_read;

   // io bit wins over ack bit
   assign a_gio = port_a_io_assign;
   // bit 0 never carries an ack
   assign a_ack = ~port_a_io_assign & port_a_ack_assign & 8'hfe;

   // set bit gives the dedicated function
   // pins 7..4 become cs when select is zero, whatever their bit
   // select high hands pins 7..4 back to the function register
   assign b_cs = full_interrupt_select ? 8'h00 : `DPP_B_CS_PINS;
   assign b_irq = port_b_function_assign & ~b_cs;
   assign b_gio = ~port_b_function_assign & ~b_cs;

   assign a_read = (a_gio & ~port_a_direction & a_pin_in) |
                   (~(a_gio & ~port_a_direction) & first_port_data);
   assign b_read = (b_gio & port_b_direction & second_port_data) |
                   (~(b_gio & port_b_direction) & b_pin_in);

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // pins lag the registers by one clock, every output from a flop
   integer i;
   always @(posedge aclk) begin
      if (!aresetn) begin
         a_pin_out <= 8'h00;
         a_pin_oe_n <= 8'hff;
         b_pin_out <= 8'h00;
         b_pin_oe_n <= 8'hff;
         core_irq_n <= 8'hff;
      end else begin
         for (i = 0; i < 8; i = i + 1) begin
            if (a_gio[i]) begin
               a_pin_out[i] <= first_port_data[i];
               a_pin_oe_n[i] <= ~port_a_direction[i];
            end else if (a_ack[i]) begin
               // low with address strobe on level match
               a_pin_out[i] <= ~(core_int_ack_active && !core_as_n &&
                                 core_int_ack_level == i[2:0]);
               a_pin_oe_n[i] <= 1'b0;
            end else begin
               // pin n carries address line 24+n
               a_pin_out[i] <= core_addr_hi[i];
               a_pin_oe_n[i] <= 1'b0;
            end
            if (b_cs[i]) begin
               // only pins 7..4 reach here
               b_pin_out[i] <= core_cs_n[i-`DPP_B_CS_BASE];
               b_pin_oe_n[i] <= 1'b0;
            end else if (b_gio[i]) begin
               b_pin_out[i] <= second_port_data[i];
               b_pin_oe_n[i] <= ~port_b_direction[i];
            end else begin
               b_pin_out[i] <= second_port_data[i];
               b_pin_oe_n[i] <= 1'b1;
            end
            // clock-mode pin gives no request after reset
            if (b_irq[i] && i != `DPP_B_CLKMODE_PIN)
               core_irq_n[i] <= b_pin_in[i];
            else
               core_irq_n[i] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------
   // address and data taken in either order, then one response
   always @* begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_bvalid = s_axi_bvalid;
      do_write = 1'b0;
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
         next_aw_got = 1'b1;
      if (s_axi_wvalid && s_axi_wready)
         next_w_got = 1'b1;
      if (aw_got && w_got && !s_axi_bvalid) begin
         do_write = 1'b1;
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_idx <= 8'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DPP_RESP_OKAY;
         full_interrupt_select <= `DPP_RST_CONFIG;
         // all port a pins start as io inputs
         port_a_io_assign <= `DPP_RST_A_IO;
         port_a_ack_assign <= `DPP_RST_A_ACK;
         port_a_direction <= `DPP_RST_DIR;
         first_port_data <= `DPP_RST_DATA;
         port_b_function_assign <= `DPP_RST_B_FUNC;
         port_b_direction <= `DPP_RST_DIR;
         second_port_data <= `DPP_RST_DATA;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         s_axi_bvalid <= next_bvalid;
         s_axi_awready <= !next_aw_got && !next_bvalid;
         s_axi_wready <= !next_w_got && !next_bvalid;
         if (s_axi_awvalid && s_axi_awready)
            aw_idx <= s_axi_awaddr[9:2];
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bresp <= `DPP_RESP_OKAY;
            case (aw_idx)
               `DPP_IDX_CONFIG: begin
                  if (w_lane0)
                     full_interrupt_select <= w_byte[`DPP_INT_SEL_BIT];
               end
               `DPP_IDX_A_IO: begin
                  if (w_lane0)
                     port_a_io_assign <= w_byte;
               end
               `DPP_IDX_A_ACK: begin
                  if (w_lane0)
                     port_a_ack_assign <= w_byte;
               end
               `DPP_IDX_A_DIR: begin
                  if (w_lane0)
                     port_a_direction <= w_byte;
               end
               `DPP_IDX_A_DATA: begin
                  if (w_lane0)
                     first_port_data <= w_byte;
               end
               `DPP_IDX_B_FUNC: begin
                  if (w_lane0)
                     port_b_function_assign <= w_byte;
               end
               `DPP_IDX_B_DIR: begin
                  if (w_lane0)
                     port_b_direction <= w_byte;
               end
               `DPP_IDX_B_DATA, `DPP_IDX_B_DATA_ALIAS: begin
                  if (w_lane0)
                     second_port_data <= w_byte;
               end
               default: begin
                  // unmapped index, no register changes
                  s_axi_bresp <= `DPP_RESP_DECERR;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // read select
   // ------------------------------------------------------------
   reg [7:0] next_rbyte;
   reg [1:0] next_rresp;

   always @* begin
      next_rbyte = 8'h00;
      next_rresp = `DPP_RESP_OKAY;
      case (s_axi_araddr[9:2])
         `DPP_IDX_CONFIG:
            next_rbyte = {7'h00, full_interrupt_select};
         `DPP_IDX_A_IO:
            next_rbyte = port_a_io_assign;
         `DPP_IDX_A_ACK:
            next_rbyte = port_a_ack_assign;
         `DPP_IDX_A_DIR:
            next_rbyte = port_a_direction;
         `DPP_IDX_A_DATA:
            next_rbyte = a_read;
         `DPP_IDX_B_FUNC:
            next_rbyte = port_b_function_assign;
         `DPP_IDX_B_DIR:
            next_rbyte = port_b_direction;
         `DPP_IDX_B_DATA, `DPP_IDX_B_DATA_ALIAS:
            next_rbyte = b_read;
         // unmapped index reads zero
         default:
            next_rresp = `DPP_RESP_DECERR;
      endcase
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   // arready stays low from the address until the data is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DPP_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= {24'h000000, next_rbyte};
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // dpp_port_ctrl

// [dpp_pin_model.sv]
// external devices on the port a and port b pins
// assumes the bench sets what each device drives on a pin the chip leaves free
`timescale 1ns/1ps
module dpp_pin_model (
   input wire [7:0] a_out,
   input wire [7:0] a_oe_n,
   input wire [7:0] b_out,
   input wire [7:0] b_oe_n,
   input wire [7:0] a_ext,
   input wire [7:0] b_ext,
   output wire [7:0] a_pin,
   output wire [7:0] b_pin
);
   // chip driver wins where enabled, else the device level
   assign a_pin = (a_oe_n & a_ext) | (~a_oe_n & a_out);
   assign b_pin = (b_oe_n & b_ext) | (~b_oe_n & b_out);
endmodule // dpp_pin_model

// [dpp_port_ctrl_checker.sv]
// assertions on the pin function ports of dpp_port_ctrl
// assumes aclk domain only; shadows config and port a io and ack assign registers from bus writes
`timescale 1ns/1ps
`include "dpp_defines.vh"
module dpp_port_ctrl_checker #(
   parameter ADDR_W = 12
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire [7:0] core_addr_hi,
   input wire core_as_n,
   input wire core_int_ack_active,
   input wire [2:0] core_int_ack_level,
   input wire [3:0] core_cs_n,
   input wire [7:0] core_irq_n,
   input wire [7:0] a_pin_out,
   input wire [7:0] a_pin_oe_n,
   input wire [7:0] b_pin_in,
   input wire [7:0] b_pin_out,
   input wire [7:0] b_pin_oe_n
);
   reg [7:0] wa, wd, aio, aack, ackv;
   reg ws, bq, int_sel;
   wire [7:0] adm = ~aio & ~(aack & 8'hfe);
   wire [7:0] akm = ~aio & aack & 8'hfe;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // shadow lags the register by one edge, as the pins do
   always @(posedge aclk) begin
      bq <= s_axi_bvalid;
      ackv <= (core_int_ack_active && !core_as_n) ? (8'h01 << core_int_ack_level) : 8'h00;
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr[9:2];
      if (s_axi_wvalid && s_axi_wready) begin
         wd <= s_axi_wdata[7:0];
         ws <= s_axi_wstrb[0];
      end
      if (!aresetn) begin
         int_sel <= 1'b0;
         aio <= 8'hff;
         aack <= 8'h00;
      end else if (s_axi_bvalid && !bq && ws) begin
         case (wa)
            `DPP_IDX_CONFIG: int_sel <= wd[`DPP_INT_SEL_BIT];
            `DPP_IDX_A_IO: aio <= wd;
            `DPP_IDX_A_ACK: aack <= wd;
            default: ;
         endcase
      end
   end
   a_addr_value: assert property (((a_pin_out ^ $past(core_addr_hi)) & adm) == 8'h00)
      else $error("address pin value wrong");
   a_addr_drive: assert property ((a_pin_oe_n & adm) == 8'h00)
      else $error("address pin not driven");
   a_ack_strobe: assert property ((((a_pin_out ^ ~ackv) | a_pin_oe_n) & akm) == 8'h00)
      else $error("ack pin wrong");
   a_cs_pins: assert property (!int_sel && $past(aresetn) |->
      b_pin_oe_n[7:4] == 4'h0 && b_pin_out[7:4] == $past(core_cs_n))
      else $error("chip select pin wrong");
   a_reset_pins: assert property ($rose(aresetn) |=> a_pin_oe_n == 8'hff && b_pin_oe_n == 8'h0f)
      else $error("pin state after reset wrong");
   a_irq_source: assert property ((~core_irq_n & $past(b_pin_in)) == 8'h00)
      else $error("irq without low pin");
   a_irq_input: assert property ((~core_irq_n & ~b_pin_oe_n) == 8'h00)
      else $error("irq on driven pin");
   a_clock_mode_inert: assert property (core_irq_n[0] == 1'b1)
      else $error("clock-mode pin raised irq");
endmodule // dpp_port_ctrl_checker
bind dpp_port_ctrl dpp_port_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .core_addr_hi(core_addr_hi), .core_as_n(core_as_n),
   .core_int_ack_active(core_int_ack_active), .core_int_ack_level(core_int_ack_level),
   .core_cs_n(core_cs_n), .core_irq_n(core_irq_n), .a_pin_out(a_pin_out),
   .a_pin_oe_n(a_pin_oe_n), .b_pin_in(b_pin_in), .b_pin_out(b_pin_out), .b_pin_oe_n(b_pin_oe_n)
);

// [test_dual_port_pin_function_control.sv]
// self-checking bench for the dual port pin function control
// assumes dpp_port_ctrl with ADDR_W 12; pins closed through dpp_pin_model
`timescale 1ns/1ps
module test_dual_port_pin_function_control;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, as_n = 1, iak = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic [1:0] rsp;
   logic [2:0] lvl = 0;
   logic [3:0] cs_n = 4'ha, e;
   logic [7:0] ahi = 8'h96, a_ext = 8'h55, b_ext = 8'h00;
   wire awr, wr, bv, arr, rv;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] irq_n, a_in, a_out, a_oe, b_in, b_out, b_oe;
   int num_errors = 0, total_checks = 0, cyc = 0, i;
   logic [25:0] rows [0:6];
   always #2.5 aclk = ~aclk;
   dpp_port_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .core_addr_hi(ahi), .core_as_n(as_n),
      .core_int_ack_active(iak), .core_int_ack_level(lvl), .core_cs_n(cs_n), .core_irq_n(irq_n),
      .a_pin_in(a_in), .a_pin_out(a_out), .a_pin_oe_n(a_oe), .b_pin_in(b_in),
      .b_pin_out(b_out), .b_pin_oe_n(b_oe));
   dpp_pin_model u_pins (.a_out(a_out), .a_oe_n(a_oe), .b_out(b_out), .b_oe_n(b_oe),
      .a_ext(a_ext), .b_ext(b_ext), .a_pin(a_in), .b_pin(b_in));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task axi_wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      awa <= {2'b00, idx, 2'b00};
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      br <= 1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
      end while (!bv);
      rsp = bresp;
      br <= 0;
   endtask
   task axi_rd(input logic [7:0] idx);
      @(posedge aclk);
      ara <= {2'b00, idx, 2'b00};
      arv <= 1;
      rr <= 1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 0;
      end while (!rv);
      rdat = rdata;
      rsp = rresp;
      rr <= 0;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   initial begin
      // index, write data, read back, response
      rows = '{{8'h13, 8'h5a, 8'h5a, 2'h0}, {8'h17, 8'hff, 8'hff, 2'h0},
         {8'h15, 8'h0f, 8'h0f, 2'h0}, {8'h1d, 8'h3c, 8'h3c, 2'h0},
         {8'h1f, 8'h0f, 8'h0f, 2'h0}, {8'h00, 8'h01, 8'h01, 2'h0}, {8'h30, 8'h77, 8'h00, 2'h3}};
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      axi_rd(8'h15);
      chk("a io reset", 32'hff, rdat);
      axi_rd(8'h1f);
      chk("b func reset", 32'hff, rdat);
      chk("a oe reset", 32'hff, a_oe);
      chk("b oe reset", 32'h0f, b_oe);
      chk("cs pins", 32'ha, b_out[7:4]);
      chk("irq reset", 32'hf1, irq_n);
      $display("reset test done");
      for (i = 0; i < 7; i++) begin
         axi_wr(rows[i][25:18], rows[i][17:10]);
         chk("write resp", rows[i][1:0], rsp);
         axi_rd(rows[i][25:18]);
         chk("read back", rows[i][9:2], rdat);
         chk("read resp", rows[i][1:0], rsp);
      end
      $display("register table done");
      axi_wr(8'h11, 8'hc3);
      @(posedge aclk);
      iak <= 1;
      as_n <= 0;
      lvl <= 3'd1;
      repeat (3) @(negedge aclk);
      chk("a oe io", 32'h05, a_oe);
      chk("a io out", 32'h2, a_out[3:0] & 4'ha);
      chk("a io wins", 32'h1, a_out[1]);
      axi_rd(8'h11);
      chk("a data read", 32'hc7, rdat);
      for (i = 4; i < 9; i++) begin
         @(posedge aclk);
         lvl <= i[2:0];
         as_n <= (i == 8);
         e = (i == 8) ? 4'hf : ~(4'h1 << (i - 4));
         repeat (3) @(negedge aclk);
         chk("ack strobe", e, a_out[7:4]);
      end
      axi_wr(8'h15, 8'h00);
      axi_wr(8'h17, 8'h01);
      repeat (3) @(negedge aclk);
      chk("addr out", 32'h96, a_out);
      chk("addr oe", 32'h00, a_oe);
      $display("port a test done");
      axi_wr(8'h1b, 8'ha5);
      @(posedge aclk);
      b_ext <= 8'h0c;
      repeat (3) @(negedge aclk);
      axi_rd(8'h19);
      chk("b data read", 32'h2c, rdat);
      chk("b oe io", 32'hcf, b_oe);
      chk("b io out", 32'h2, b_out[5:4]);
      chk("b irq", 32'hfd, irq_n);
      $display("port b test done");
      tally_and_finish;
   end
endmodule // test_dual_port_pin_function_control
